// >>> logic/eng_pkg.sv
// Purpose: shared constants and types for the sample output engine
// Assumes: one modulator clock drives the whole datapath
// Notes: coefficient tables hold the first half plus the centre tap
package eng_pkg;
	localparam int SW       = 16;
	localparam int TAPS_MAX = 63;

	// register map, byte-wide registers on a 9-bit address
	localparam logic [8:0] ADDR_BW   = 9'h00f;
	localparam logic [8:0] ADDR_FMT  = 9'h014;
	localparam logic [8:0] ADDR_FAC  = 9'h101;
	localparam logic [8:0] ADDR_STAT = 9'h102;
	localparam int         BW_LSB    = 5;

	// values after reset
	localparam logic [1:0] BW_RST  = 2'h0;
	localparam logic [1:0] FMT_RST = 2'h0;
	localparam logic [5:0] FAC_RST = 6'h00;

	// resampler: accumulator counts half clocks
	localparam logic [5:0]  FAC_TOP4 = 6'h08; // codes up to here mean 4
	localparam logic [6:0]  ACC_STEP = 7'h02; // two halves per clock
	localparam logic [15:0] MOD_LVL  = 16'h2000; // weight of one bit

	// filter lengths and output shifts
	localparam int Q_N   = 23;
	localparam int L_N   = 63;
	localparam int I1_N  = 27;
	localparam int I2_N  = 15;
	localparam int Q_SH  = 15;
	localparam int L_SH  = 16;
	localparam int I1_SH = 15;
	localparam int I2_SH = 13;

	typedef logic [TAPS_MAX-1:0][SW-1:0] taps_t;
	typedef int coef_t [32];

	localparam coef_t Q_HALF = '{0: -21, 2: 122, 4: -418, 6: 1121,
		8: -2796, 10: 10184, 11: 16384, default: 0};
	localparam coef_t L_HALF = '{17, 31, -15, -52, 36, 78, -84, -98,
		170, 97, -291, -42, 441, -98, -592, 353, 694, -744, -677, 1271,
		450, -1909, 103, 2612, -1147, -3326, 3022, 4051, -6870, -5305,
		21141, 38956};
	localparam coef_t I1_HALF = '{0: 15, 2: -97, 4: 361, 6: -1017,
		8: 2450, 10: -5761, 12: 20433, 13: 32768, default: 0};
	localparam coef_t I2_HALF = '{0: -27, 2: 227, 4: -1032, 6: 4928,
		7: 8192, default: 0};

	typedef enum logic [1:0] {
		FMT_OFFSET = 2'h0,
		FMT_TWOS   = 2'h1,
		FMT_GRAY   = 2'h2
	} fmt_t;

	typedef enum logic [3:0] {
		W_LOAD = 4'h1,
		W_RISE = 4'h2,
		W_HIGH = 4'h4,
		W_DONE = 4'h8
	} word_st_t;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

	typedef struct packed {
		logic [2:0][19:0] in;
		logic [2:0][19:0] dl;
		logic             ph;
		logic [SW-1:0]    y;
		logic             v;
	} cic_t;
endpackage

// >>> logic/sample_out_engine.sv
// Purpose: decimate a modulator bit stream, resample, emit 16-bit words
// Assumes: I_CLK is the modulator clock; bus inputs are synchronous
// Notes: all arithmetic is single-cycle; the fir paths are long
`timescale 1ns/1ns

module sample_out_engine (
	input  wire logic              I_CLK,     // modulator clock
	input  wire logic              I_RST,     // async reset, high
	input  wire logic              I_MOD_BIT, // modulator bit stream
	input  wire eng_pkg::bus_req_t I_BUS,     // register access
	output logic [7:0]             O_RDATA,   // read data, next cycle
	output logic [15:0]            O_DATA,    // formatted sample word
	output logic                   O_SAMPLE_WORD_CLOCK_OUT // word clock
);
	typedef struct packed {
		logic [1:0]                     bw;
		logic [1:0]                     fmt;
		logic [5:0]                     fac;
		logic [7:0]                     rdata;
		eng_pkg::cic_t [1:0]            cic;
		logic [eng_pkg::Q_N-1:0][15:0]  q_sr;
		logic [1:0]                     q_ph;
		logic [15:0]                    q_y;
		logic                           q_v;
		logic [eng_pkg::L_N-1:0][15:0]  l_sr;
		logic [15:0]                    l_y;
		logic                           l_v;
		logic [eng_pkg::I1_N-1:0][15:0] i1_sr;
		logic [1:0]                     i1_ph;
		logic [15:0]                    i1_y;
		logic                           i1_v;
		logic [eng_pkg::I2_N-1:0][15:0] i2_sr;
		logic                           i2_ph;
		logic [15:0]                    i2_y;
		logic [6:0]                     acc;
		logic [15:0]                    out;
		eng_pkg::word_st_t              wst;
		logic                           sample_word_clock_out;
	} state_t;

	state_t      s_q;
	state_t      s_d;
	logic        emit;
	logic [15:0] xin;
	logic [15:0] dx;
	logic        dv;
	logic [6:0]  nxt;
	logic [6:0]  rem;

	// round half up, then clip to the 16-bit sample range
	function automatic logic [15:0] sat_f(input logic signed [47:0] a,
		input int sh);
		logic signed [47:0] r;
		r = (a + (48'sh1 <<< (sh - 1))) >>> sh;
		if (r[47:15] != {33{r[15]}})
			return r[47] ? 16'h8000 : 16'h7fff;
		return r[15:0];
	endfunction

	// symmetric fir; only the half table is stored, index is mirrored
	function automatic logic [15:0] fir_f(input eng_pkg::taps_t t,
		input int n, input eng_pkg::coef_t c, input int sh);
		logic signed [47:0] acc;
		acc = '0;
		for (int k = 0; k < eng_pkg::TAPS_MAX; k++) begin
			if (k < n)
				acc = acc + 48'($signed(t[k]) *
					c[(2 * k < n) ? k : n - 1 - k]);
		end
		return sat_f(acc, sh);
	endfunction

	// plain sinc3 decimate-by-two: three integrators, three combs
	function automatic eng_pkg::cic_t cic_f(input eng_pkg::cic_t c,
		input logic [15:0] x, input logic v);
		eng_pkg::cic_t r;
		logic [19:0]   c1;
		logic [19:0]   c2;
		logic [19:0]   c3;
		r  = c;
		r.v = 1'b0;
		c1 = '0;
		c2 = '0;
		c3 = '0;
		if (v) begin
			r.in[0] = c.in[0] + 20'($signed(x));
			r.in[1] = c.in[1] + r.in[0];
			r.in[2] = c.in[2] + r.in[1];
			r.ph    = ~c.ph;
			if (c.ph) begin
				c1      = r.in[2] - c.dl[0];
				c2      = c1 - c.dl[1];
				c3      = c2 - c.dl[2];
				r.dl[0] = r.in[2];
				r.dl[1] = c1;
				r.dl[2] = c2;
				r.y     = c3[18:3]; // gain of eight removed
				r.v     = 1'b1;
			end
		end
		return r;
	endfunction

	// divide factor in half clocks; low codes all mean eight, i.e. four clocks
	function automatic logic [6:0] eff_f(input logic [5:0] code);
		if (code <= eng_pkg::FAC_TOP4)
			return {1'b0, eng_pkg::FAC_TOP4};
		return {1'b0, code};
	endfunction

	// gray is taken from the offset binary word
	function automatic logic [15:0] fmt_f(input logic [15:0] w,
		input logic [1:0] f);
		logic [15:0] ob;
		ob = {~w[15], w[14:0]};
		case (f)
		eng_pkg::FMT_TWOS: return w;
		eng_pkg::FMT_GRAY: return ob ^ (ob >> 1);
		default:           return ob;
		endcase
	endfunction

	// whole engine next state
	always_comb begin
		s_d       = s_q;
		emit      = 1'b0;
		s_d.rdata = '0;
		xin = I_MOD_BIT ? eng_pkg::MOD_LVL : -eng_pkg::MOD_LVL;

		// register writes; strobes never coincide
		if (I_BUS.wr) begin
			if (I_BUS.addr == eng_pkg::ADDR_BW) begin
				s_d.bw = I_BUS.wdata[eng_pkg::BW_LSB +: 2];
			end else if (I_BUS.addr == eng_pkg::ADDR_FMT) begin
				s_d.fmt = I_BUS.wdata[1:0];
			end else if (I_BUS.addr == eng_pkg::ADDR_FAC) begin
				s_d.fac = I_BUS.wdata[5:0];
			end
		end

		// register reads; unmapped reads return zero
		if (I_BUS.rd) begin
			if (I_BUS.addr == eng_pkg::ADDR_BW) begin
				s_d.rdata[eng_pkg::BW_LSB +: 2] = s_q.bw;
			end else if (I_BUS.addr == eng_pkg::ADDR_FMT) begin
				s_d.rdata[1:0] = s_q.fmt;
			end else if (I_BUS.addr == eng_pkg::ADDR_FAC) begin
				s_d.rdata[5:0] = s_q.fac;
			end else if (I_BUS.addr == eng_pkg::ADDR_STAT) begin
				s_d.rdata[0] = (s_q.fac != '0);
				s_d.rdata[1] = s_q.sample_word_clock_out;
			end
		end

		// both sinc stages always run; bw picks the tap point
		s_d.cic[0] = cic_f(s_q.cic[0], xin, 1'b1);
		s_d.cic[1] = cic_f(s_q.cic[1], s_q.cic[0].y, s_q.cic[0].v);
		if (s_q.bw == 2'h0) begin
			dx = xin;
			dv = 1'b1;
		end else if (s_q.bw == 2'h1) begin
			dx = s_q.cic[0].y;
			dv = s_q.cic[0].v;
		end else begin
			dx = s_q.cic[1].y;
			dv = s_q.cic[1].v;
		end

		// quarter decimator: one output per four inputs
		s_d.q_v = 1'b0;
		if (dv) begin
			s_d.q_sr = {s_q.q_sr[eng_pkg::Q_N-2:0], dx};
			s_d.q_ph = s_q.q_ph + 2'h1;
			if (s_q.q_ph == 2'h3) begin
				s_d.q_y = fir_f(eng_pkg::taps_t'(s_d.q_sr), eng_pkg::Q_N,
					eng_pkg::Q_HALF, eng_pkg::Q_SH);
				s_d.q_v = 1'b1;
			end
		end

		// band low-pass, also flattens the sinc droop
		s_d.l_v = 1'b0;
		if (s_q.q_v) begin
			s_d.l_sr = {s_q.l_sr[eng_pkg::L_N-2:0], s_q.q_y};
			s_d.l_y  = fir_f(eng_pkg::taps_t'(s_d.l_sr), eng_pkg::L_N,
				eng_pkg::L_HALF, eng_pkg::L_SH);
			s_d.l_v  = 1'b1;
		end

		// first interpolator; zero pushed two clocks later so the
		// second one never sees two pushes in one clock
		s_d.i1_v = 1'b0;
		if (s_q.l_v) begin
			s_d.i1_sr = {s_q.i1_sr[eng_pkg::I1_N-2:0], s_q.l_y};
			s_d.i1_ph = 2'h2;
			s_d.i1_v  = 1'b1;
		end else if (s_q.i1_ph == 2'h2) begin
			s_d.i1_ph = 2'h1;
		end else if (s_q.i1_ph == 2'h1) begin
			s_d.i1_sr = {s_q.i1_sr[eng_pkg::I1_N-2:0], 16'h0000};
			s_d.i1_ph = 2'h0;
			s_d.i1_v  = 1'b1;
		end
		if (s_d.i1_v)
			s_d.i1_y = fir_f(eng_pkg::taps_t'(s_d.i1_sr), eng_pkg::I1_N,
				eng_pkg::I1_HALF, eng_pkg::I1_SH);

		// second interpolator; zero follows in the next clock
		if (s_q.i1_v) begin
			s_d.i2_sr = {s_q.i2_sr[eng_pkg::I2_N-2:0], s_q.i1_y};
			s_d.i2_ph = 1'b1;
		end else if (s_q.i2_ph) begin
			s_d.i2_sr = {s_q.i2_sr[eng_pkg::I2_N-2:0], 16'h0000};
			s_d.i2_ph = 1'b0;
		end
		if (s_q.i1_v || s_q.i2_ph)
			s_d.i2_y = fir_f(eng_pkg::taps_t'(s_d.i2_sr), eng_pkg::I2_N,
				eng_pkg::I2_HALF, eng_pkg::I2_SH);

		// resampler: fractional divider picks the held i2 value,
		// a zero-order hold, i.e. a first-order sinc
		nxt = s_q.acc + eng_pkg::ACC_STEP;
		rem = nxt - eff_f(s_q.fac);
		if (s_q.fac == '0) begin
			s_d.acc = '0;
		end else if (nxt >= eff_f(s_q.fac)) begin
			emit    = 1'b1;
			s_d.acc = (rem >= eng_pkg::ACC_STEP) ? '0 : rem;
		end else begin
			s_d.acc = nxt;
		end

		// word out, clock low one cycle, high two, then low
		if (emit) begin
			s_d.out = fmt_f(s_q.i2_y, s_q.fmt);
			s_d.wst = eng_pkg::W_LOAD;
		end else begin
			case (s_q.wst)
			eng_pkg::W_LOAD: s_d.wst = eng_pkg::W_RISE;
			eng_pkg::W_RISE: s_d.wst = eng_pkg::W_HIGH;
			default:         s_d.wst = eng_pkg::W_DONE;
			endcase
		end
		s_d.sample_word_clock_out = (s_d.wst == eng_pkg::W_RISE) ||
			(s_d.wst == eng_pkg::W_HIGH);
	end

	// single state register
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			s_q     <= '0;
			s_q.bw  <= eng_pkg::BW_RST;
			s_q.fmt <= eng_pkg::FMT_RST;
			s_q.fac <= eng_pkg::FAC_RST;
			s_q.wst <= eng_pkg::W_DONE;
		end else begin
			s_q <= s_d;
		end
	end

	assign O_RDATA                 = s_q.rdata;
	assign O_DATA                  = s_q.out;
	assign O_SAMPLE_WORD_CLOCK_OUT = s_q.sample_word_clock_out;

	// checks on the engine's outputs and its internal pipeline state
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	property p_gap;
		emit |=> !emit [*3];
	endproperty
	a_gap: assert property (p_gap)
		else $error("words closer than four clocks");

	property p_zero;
		(s_q.fac == 6'h00) |=> $stable(O_DATA);
	endproperty
	a_zero: assert property (p_zero)
		else $error("word emitted while factor is zero");

	property p_four;
		(emit && s_q.fac inside {[1:8]}) ##1 $stable(s_q.fac) [*4]
			|-> emit;
	endproperty
	a_four: assert property (p_four)
		else $error("low codes do not give a period of four");

	property p_wclk;
		emit |=> !O_SAMPLE_WORD_CLOCK_OUT ##1
			O_SAMPLE_WORD_CLOCK_OUT [*2] ##1 !O_SAMPLE_WORD_CLOCK_OUT;
	endproperty
	a_wclk: assert property (p_wclk)
		else $error("word clock shape wrong");

	property p_hold;
		emit |=> ##1 $stable(O_DATA) [*3];
	endproperty
	a_hold: assert property (p_hold)
		else $error("word changed around capture edge");

	property p_twos;
		(emit && s_q.fmt == eng_pkg::FMT_TWOS) |=>
			(O_DATA == $past(s_q.i2_y));
	endproperty
	a_twos: assert property (p_twos)
		else $error("two's complement word wrong");

	property p_offs;
		(emit && s_q.fmt == eng_pkg::FMT_OFFSET) |=>
			(O_DATA == ($past(s_q.i2_y) ^ 16'h8000));
	endproperty
	a_offs: assert property (p_offs)
		else $error("offset binary word wrong");

	property p_bw0;
		(s_q.bw == 2'h0 && s_q.q_ph == 2'h3) |=> s_q.q_v;
	endproperty
	a_bw0: assert property (p_bw0)
		else $error("full band does not bypass sinc stages");

	property p_dec;
		s_q.q_v |=> !s_q.q_v [*3];
	endproperty
	a_dec: assert property (p_dec)
		else $error("quarter decimator too fast");

	property p_int;
		s_q.l_v |=> s_q.i1_v ##1 !s_q.i1_v ##1 s_q.i1_v;
	endproperty
	a_int: assert property (p_int)
		else $error("first interpolator pair misplaced");

	c_emit: cover property (emit);
	c_rise: cover property ($rose(O_SAMPLE_WORD_CLOCK_OUT));
	c_rst:  cover property (s_q.fac == 6'h00 ##1 s_q.fac != 6'h00);
	c_gray: cover property (emit && s_q.fmt == eng_pkg::FMT_GRAY);
endmodule

// >>> sim/word_receiver.sv
// Purpose: receiving logic that latches each word on the word clock
// Assumes: words are captured on the rising edge of the word clock
// Notes: no reset, like a plain capture register; stamps count cycles
`timescale 1ns/1ns
module word_receiver (
	input  wire logic        i_clk,  // system clock, for stamping
	input  wire logic [15:0] i_data, // parallel sample word
	input  wire logic        i_wclk, // word clock from the engine
	output logic [15:0]      o_word, // last captured word
	output int               o_count, // words captured so far
	output int               o_stamp, // cycle of last capture
	output logic             o_bad   // word moved while clock high
);
	int cyc = 0;

	initial begin
		o_word = 16'h0000;
		o_count = 0;
		o_stamp = 0;
		o_bad = 1'b0;
	end

	// free cycle count gives capture spacing
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (i_wclk && i_data !== o_word) begin
			o_bad <= 1'b1;
		end
	end

	// capture edge; one word per pulse
	always @(posedge i_wclk) begin
		o_word <= i_data;
		o_count <= o_count + 1;
		o_stamp <= cyc;
	end
endmodule

// >>> sim/test_sample_out_engine.sv
// Purpose: self-checking bench for the sample output engine
// Assumes: dc input settles well inside 3000 cycles at any bandwidth
// Notes: formats are judged against the two's complement word seen
`timescale 1ns/1ns
module test_sample_out_engine;
	logic              clk;
	logic              rst;
	logic              bit_in;
	eng_pkg::bus_req_t bus;
	logic [7:0]        rdata;
	logic [15:0]       data;
	logic              wclk;
	logic [15:0]       word;
	int                count;
	int                stamp;
	logic              bad;
	int                num_errors;
	int                checked;

	sample_out_engine DUT (.I_CLK(clk), .I_RST(rst), .I_MOD_BIT(bit_in),
		.I_BUS(bus), .O_RDATA(rdata), .O_DATA(data),
		.O_SAMPLE_WORD_CLOCK_OUT(wclk));
	word_receiver rx (.i_clk(clk), .i_data(data), .i_wclk(wclk),
		.o_word(word), .o_count(count), .o_stamp(stamp), .o_bad(bad));

	// 100 ns period
	always #50 clk = ~clk;

	task automatic cmp_b(input string n, input logic [7:0] e,
		input logic [7:0] s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cmp_w(input string n, input logic [15:0] e,
		input logic [15:0] s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cmp_n(input string n, input int e, input int s);
		checked++;
		if (s != e) begin
			num_errors++;
			$display("[ERR] %s expected %0d seen %0d", n, e, s);
		end
	endtask

	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		cmp_b("rdata", e, rdata);
	endtask

	// bounded wait for n more captured words
	task automatic words(input int n);
		int c0;
		int k;
		c0 = count;
		for (k = 0; k < 400 * n && count < c0 + n; k++)
			@(posedge clk);
		cmp_n("words", c0 + n, count);
	endtask

	task automatic t_reset();
		cmp_w("data", 16'h0000, data);
		cmp_b("wclk", 8'h00, {7'h00, wclk});
		rd(eng_pkg::ADDR_BW, 8'h00);
		rd(eng_pkg::ADDR_FMT, 8'h00);
		rd(eng_pkg::ADDR_FAC, 8'h00);
		rd(eng_pkg::ADDR_STAT, 8'h00);
		rd(9'h1ff, 8'h00);
	endtask

	// spare bits read 0, unmapped write leaves fields alone
	task automatic t_regs();
		wr(eng_pkg::ADDR_BW, 8'hff);
		wr(eng_pkg::ADDR_FMT, 8'hff);
		wr(9'h1ff, 8'h00);
		rd(eng_pkg::ADDR_BW, 8'h60);
		rd(eng_pkg::ADDR_FMT, 8'h03);
		wr(eng_pkg::ADDR_FAC, 8'hff);
		rd(eng_pkg::ADDR_FAC, 8'h3f);
		wr(eng_pkg::ADDR_FAC, 8'h00);
		wr(eng_pkg::ADDR_BW, 8'h00);
		wr(eng_pkg::ADDR_FMT, 8'h00);
	endtask

	task automatic t_idle();
		int c0;
		c0 = count;
		repeat (100) @(posedge clk);
		cmp_n("idle words", c0, count);
		rd(eng_pkg::ADDR_STAT, 8'h00);
	endtask

	// two periods span the effective code in whole clocks
	task automatic t_rate(input logic [5:0] code, input int span);
		int t0;
		wr(eng_pkg::ADDR_FAC, 8'h00);
		wr(eng_pkg::ADDR_FAC, {2'h0, code});
		// read before the first new word: word clock still low here
		rd(eng_pkg::ADDR_STAT, 8'h01);
		words(2);
		t0 = stamp;
		words(2);
		cmp_n("two periods", span, stamp - t0);
	endtask

	task automatic t_format();
		logic [15:0] w2;
		logic [15:0] ob;
		int          d;
		bit_in <= 1'b1;
		wr(eng_pkg::ADDR_FMT, 8'h01);
		repeat (3000) @(posedge clk);
		words(1);
		w2 = word;
		d = int'($signed(w2)) - 8192;
		cmp_n("dc level", 1, int'(d < 512 && d > -512));
		words(8);
		cmp_w("steady", w2, word);
		ob = w2 ^ 16'h8000;
		wr(eng_pkg::ADDR_FMT, 8'h00);
		words(2);
		cmp_w("offset", ob, word);
		wr(eng_pkg::ADDR_FMT, 8'h02);
		words(2);
		cmp_w("gray", ob ^ (ob >> 1), word);
		wr(eng_pkg::ADDR_FMT, 8'h03);
		words(2);
		cmp_w("code 3", ob, word);
	endtask

	// sign of the settled word follows the bit stream density
	task automatic t_bw(input logic [7:0] bw, input logic b);
		bit_in <= b;
		wr(eng_pkg::ADDR_BW, bw);
		wr(eng_pkg::ADDR_FMT, 8'h01);
		repeat (3000) @(posedge clk);
		words(1);
		cmp_b("sign", {7'h00, ~b}, {7'h00, word[15]});
	endtask

	task automatic t_rst2();
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		cmp_w("data", 16'h0000, data);
		rd(eng_pkg::ADDR_FAC, 8'h00);
		t_idle();
		t_rate(6'd20, 20);
	endtask

	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// cut a hang well past the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		conclude();
	end

	// main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		bit_in = 1'b0;
		bus = '0;
		num_errors = 0;
		checked = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_idle();
		t_rate(6'd1, 8);
		t_rate(6'd8, 8);
		t_rate(6'd9, 9);
		t_rate(6'd10, 10);
		t_rate(6'd63, 63);
		t_rate(6'd8, 8);
		t_format();
		t_bw(8'h20, 1'b1);
		t_bw(8'h40, 1'b0);
		t_bw(8'h60, 1'b1);
		cmp_b("capture", 8'h00, {7'h00, bad});
		t_rst2();
		conclude();
	end
endmodule
